/* File: rtl/edge_if.sv */
// Falling-edge detector carrier between top and detector
`default_nettype none
interface edge_if;
    logic pin;
    logic fall;
    modport det (input pin, output fall);
    modport top (output pin, input fall);
endinterface
`default_nettype wire

/* File: rtl/fall_detect.sv */
// Two-flop synchroniser with falling-edge pulse
`default_nettype none
module fall_detect (
    input wire logic aclk,
    input wire logic aresetn,
    edge_if.det e
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic fall;
    } st_t;
    st_t q, d;
    always_comb begin
        d = q;
        d.s1 = e.pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.fall = q.s3 & ~q.s2;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // All low: no false edge after reset, whatever the pin level
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign e.fall = q.fall;
endmodule
`default_nettype wire

/* File: rtl/quad_timer_counter_unit.sv */
// Four counter/timers with AXI4-Lite registers and interrupt
//
// Overview of operation
// - Four 16-bit timers: two classic counter/timers, two auto-reload timers.
// - Timers 0/1: 13-bit, 16-bit, 8-bit reload, split (timer 0 only).
// - Timers 2/3: 16-bit reload or two independent 8-bit reload halves.
// - Timer 3 keeps counting external clock in suspend and wakes device.
// - Timers 0/1 pick among five sources via select bit and prescale.
// - Each of timers 0/1 counts prescaled clock or raw system clock.
// - Timers 2/3 use system clock, system/12, or external/8.
// - Counter operation increments on each falling edge of event pin.
// - Edge counting works up to half of system clock rate.
// - 13-bit rollover 0x1fff to zero sets overflow flag and interrupt.
// - Count only with run set and, except split high byte, gate clear or gate input high.
// - Prescale 00 /12, 01 /4, 10 /48, 11 external /8 synchronised.
// - Clock select 0 prescaled, 1 system; ignored in counter operation.
`default_nettype none
module quad_timer_counter_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_zero_event_pin,
    input wire logic timer_one_event_pin,
    input wire logic external_gate_input_zero,
    input wire logic external_gate_input_one,
    input wire logic ext_osc_clk,
    output logic irq,
    output logic wake
);
    typedef struct packed {
        logic awdone;
        logic wdone;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [7:0] clkcfg;
        logic [5:0] stat;
        logic [5:0] mask;
        logic [15:0] t0;
        logic [15:0] t1;
        logic [15:0] t2;
        logic [15:0] t3;
        logic [15:0] t2rl;
        logic [15:0] t3rl;
        logic irq;
        logic wake;
        logic awrdy;
        logic wrdy;
        logic arrdy;
    } st_t;
    st_t q, d;

    // Status bits: 0 t0 ovf, 1 t1 ovf, 2 t0 high ovf (split), 3 t2, 4 t3, 5 t2/t3 low halves
    edge_if e0 ();
    edge_if e1 ();
    edge_if ex ();
    assign e0.pin = timer_zero_event_pin;
    assign e1.pin = timer_one_event_pin;
    assign ex.pin = ext_osc_clk;
    fall_detect u_fd0 (.aclk(aclk), .aresetn(aresetn), .e(e0));
    fall_detect u_fd1 (.aclk(aclk), .aresetn(aresetn), .e(e1));
    fall_detect u_fdx (.aclk(aclk), .aresetn(aresetn), .e(ex));

    // Shared base ticks: system clock /4, /12, /48 and external clock /8
    logic tick4, tick12, tick48, ext8;
    tick_div #(.W(6)) u_d4 (.aclk(aclk), .aresetn(aresetn), .en(1'b1),
        .n(6'(timer_pkg::DIV4)), .tick(tick4));
    tick_div #(.W(6)) u_d12 (.aclk(aclk), .aresetn(aresetn), .en(1'b1),
        .n(6'(timer_pkg::DIV12)), .tick(tick12));
    tick_div #(.W(6)) u_d48 (.aclk(aclk), .aresetn(aresetn), .en(1'b1),
        .n(6'(timer_pkg::DIV48)), .tick(tick48));
    tick_div #(.W(6)) u_dx (.aclk(aclk), .aresetn(aresetn), .en(ex.fall),
        .n(6'(timer_pkg::EXT_DIV)), .tick(ext8));

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic t23_tick(input logic [1:0] sel, input logic t12, input logic x8);
        unique case (sel)
            timer_pkg::CK_SYS: return 1'b1;
            timer_pkg::CK_DIV12: return t12;
            timer_pkg::CK_EXT8: return x8;
            default: return 1'b0;
        endcase
    endfunction

    logic presc, en0, en1, en2, en3, susp;
    logic [1:0] mode0, mode1;
    logic ov0, ov1, ov0h, ov2, ov3, ovl;
    logic [15:0] n0, n1, n2, n3;
    logic wr_go, rd_go;

    always_comb begin
        unique case (q.clkcfg[timer_pkg::CFG_PS +: 2])
            timer_pkg::PS_DIV12: presc = tick12;
            timer_pkg::PS_DIV4: presc = tick4;
            timer_pkg::PS_DIV48: presc = tick48;
            default: presc = ext8;
        endcase
    end

    always_comb begin
        mode0 = q.ctrl[timer_pkg::CTRL_MODE0 +: 2];
        mode1 = q.ctrl[timer_pkg::CTRL_MODE1 +: 2];
        susp = q.ctrl[timer_pkg::CTRL_SUSP];
        // Counter mode ignores the clock select
        en0 = q.ctrl[timer_pkg::CTRL_CNT0] ? e0.fall :
              (q.clkcfg[timer_pkg::CFG_CS0] ? 1'b1 : presc);
        en1 = q.ctrl[timer_pkg::CTRL_CNT1] ? e1.fall :
              (q.clkcfg[timer_pkg::CFG_CS1] ? 1'b1 : presc);
        // Gate logic
        en0 = en0 & q.ctrl[timer_pkg::CTRL_RUN0] & ~susp &
              (~q.ctrl[timer_pkg::CTRL_TIMER_ZERO_GATE_BIT] | external_gate_input_zero);
        en1 = en1 & q.ctrl[timer_pkg::CTRL_RUN1] & ~susp &
              (~q.ctrl[timer_pkg::CTRL_GATE1] | external_gate_input_one);
        // only timer 3 survives suspend, and only on external clock
        en2 = t23_tick(q.clkcfg[timer_pkg::CFG_T2CK +: 2], tick12, ext8) &
              q.ctrl[timer_pkg::CTRL_RUN2] & ~susp;
        en3 = t23_tick(q.clkcfg[timer_pkg::CFG_T3CK +: 2], tick12, ext8) &
              q.ctrl[timer_pkg::CTRL_RUN3] &
              (~susp | q.clkcfg[timer_pkg::CFG_T3CK +: 2] == timer_pkg::CK_EXT8);
    end

    // Timer 0 and 1 counting
    always_comb begin
        n0 = q.t0;
        ov0 = 1'b0;
        ov0h = 1'b0;
        n1 = q.t1;
        ov1 = 1'b0;
        if (en0) begin
            unique case (mode0)
                timer_pkg::MODE_13: begin
                    {ov0, n0[15:8], n0[4:0]} = {1'b0, q.t0[15:8], q.t0[4:0]} + 14'h1;
                    n0[7:5] = 3'h0;
                end
                timer_pkg::MODE_16: {ov0, n0} = {1'b0, q.t0} + 17'h1;
                timer_pkg::MODE_8RL: begin
                    ov0 = &q.t0[7:0];
                    n0[7:0] = ov0 ? q.t0[15:8] : q.t0[7:0] + 8'h1;
                end
                default: {ov0, n0[7:0]} = {1'b0, q.t0[7:0]} + 9'h1;
            endcase
        end
        // Split high byte runs from timer 1's run bit on plain clock
        if (mode0 == timer_pkg::MODE_SPLIT && q.ctrl[timer_pkg::CTRL_RUN1] && !susp &&
            (q.clkcfg[timer_pkg::CFG_CS0] || presc)) begin
            {ov0h, n0[15:8]} = {1'b0, q.t0[15:8]} + 9'h1;
        end
        // Timer 1 has no split mode; it holds there
        if (en1) begin
            unique case (mode1)
                timer_pkg::MODE_13: begin
                    {ov1, n1[15:8], n1[4:0]} = {1'b0, q.t1[15:8], q.t1[4:0]} + 14'h1;
                    n1[7:5] = 3'h0;
                end
                timer_pkg::MODE_16: {ov1, n1} = {1'b0, q.t1} + 17'h1;
                timer_pkg::MODE_8RL: begin
                    ov1 = &q.t1[7:0];
                    n1[7:0] = ov1 ? q.t1[15:8] : q.t1[7:0] + 8'h1;
                end
                default: n1 = q.t1;
            endcase
        end
    end

    // Timers 2 and 3: 16-bit reload or split halves
    always_comb begin
        n2 = q.t2;
        n3 = q.t3;
        ov2 = 1'b0;
        ov3 = 1'b0;
        ovl = 1'b0;
        if (en2) begin
            if (q.ctrl[timer_pkg::CTRL_SPLIT2]) begin
                n2[7:0] = &q.t2[7:0] ? q.t2rl[7:0] : q.t2[7:0] + 8'h1;
                n2[15:8] = &q.t2[15:8] ? q.t2rl[15:8] : q.t2[15:8] + 8'h1;
                ovl = &q.t2[7:0];
                ov2 = &q.t2[15:8];
            end else begin
                ov2 = &q.t2;
                n2 = ov2 ? q.t2rl : q.t2 + 16'h1;
            end
        end
        if (en3) begin
            if (q.ctrl[timer_pkg::CTRL_SPLIT3]) begin
                n3[7:0] = &q.t3[7:0] ? q.t3rl[7:0] : q.t3[7:0] + 8'h1;
                n3[15:8] = &q.t3[15:8] ? q.t3rl[15:8] : q.t3[15:8] + 8'h1;
                ovl = ovl | &q.t3[7:0];
                ov3 = &q.t3[15:8];
            end else begin
                ov3 = &q.t3;
                n3 = ov3 ? q.t3rl : q.t3 + 16'h1;
            end
        end
    end

    assign wr_go = q.awdone && q.wdone && !q.bvalid;
    assign rd_go = s_axi_arvalid && q.arrdy;

    always_comb begin
        d = q;
        d.t0 = n0;
        d.t1 = n1;
        d.t2 = n2;
        d.t3 = n3;
        if (s_axi_awvalid && q.awrdy) begin
            d.awdone = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wrdy) begin
            d.wdone = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp = 2'h0;
            unique case (s_axi_araddr)
                timer_pkg::OFF_CTRL: d.rdata = q.ctrl;
                timer_pkg::OFF_CLKCFG: d.rdata = {24'h0, q.clkcfg};
                timer_pkg::OFF_STAT: d.rdata = {26'h0, q.stat};
                timer_pkg::OFF_MASK: d.rdata = {26'h0, q.mask};
                timer_pkg::OFF_T0: d.rdata = {16'h0, q.t0};
                timer_pkg::OFF_T1: d.rdata = {16'h0, q.t1};
                timer_pkg::OFF_T2: d.rdata = {16'h0, q.t2};
                timer_pkg::OFF_T3: d.rdata = {16'h0, q.t3};
                timer_pkg::OFF_T2RL: d.rdata = {16'h0, q.t2rl};
                timer_pkg::OFF_T3RL: d.rdata = {16'h0, q.t3rl};
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = 2'h2;
                end
            endcase
            if (s_axi_araddr == timer_pkg::OFF_STAT) begin
                d.stat = 6'h0; // Read clears; new events below still win
            end
        end
        if (wr_go) begin
            d.awdone = 1'b0;
            d.wdone = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = 2'h0;
            // Register writes beat a same-cycle count update
            unique case (q.awaddr)
                // Strobes only matter on control; counters take the whole word
                timer_pkg::OFF_CTRL: d.ctrl = wmerge(q.ctrl, q.wdata, q.wstrb);
                timer_pkg::OFF_CLKCFG: d.clkcfg = q.wdata[7:0];
                timer_pkg::OFF_STAT: ;
                timer_pkg::OFF_MASK: d.mask = q.wdata[5:0];
                timer_pkg::OFF_T0: d.t0 = q.wdata[15:0];
                timer_pkg::OFF_T1: d.t1 = q.wdata[15:0];
                timer_pkg::OFF_T2: d.t2 = q.wdata[15:0];
                timer_pkg::OFF_T3: d.t3 = q.wdata[15:0];
                timer_pkg::OFF_T2RL: d.t2rl = q.wdata[15:0];
                timer_pkg::OFF_T3RL: d.t3rl = q.wdata[15:0];
                default: d.bresp = 2'h2;
            endcase
        end
        // Sticky events; set wins over read-clear
        d.stat = d.stat | {ovl, ov3, ov2, ov0h, ov1, ov0};
        d.irq = |(d.stat & q.mask);
        d.wake = susp & ov3;
        // Registered readies; no new write while its answer stands
        d.awrdy = ~d.awdone & ~d.bvalid;
        d.wrdy = ~d.wdone & ~d.bvalid;
        d.arrdy = ~d.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awrdy;
    assign s_axi_wready = q.wrdy;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arrdy;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign irq = q.irq;
    assign wake = q.wake;
endmodule
`default_nettype wire

/* File: rtl/tick_div.sv */
// Counter producing a one-cycle tick every n enabled inputs
`default_nettype none
module tick_div #(
    parameter int W = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic en,
    input wire logic [W-1:0] n,
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } st_t;
    st_t q, d;
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (en) begin
            if (q.cnt >= n - W'(1)) begin
                d.cnt = '0;
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + W'(1);
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign tick = q.tick;
endmodule
`default_nettype wire

/* File: rtl/timer_pkg.sv */
// Shared constants for the quad timer unit
`default_nettype none
package timer_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CLKCFG = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0c;
    localparam logic [7:0] OFF_T0 = 8'h10;
    localparam logic [7:0] OFF_T1 = 8'h14;
    localparam logic [7:0] OFF_T2 = 8'h18;
    localparam logic [7:0] OFF_T3 = 8'h1c;
    localparam logic [7:0] OFF_T2RL = 8'h20;
    localparam logic [7:0] OFF_T3RL = 8'h24;
    // Timer 0/1 modes
    localparam logic [1:0] MODE_13 = 2'h0;
    localparam logic [1:0] MODE_16 = 2'h1;
    localparam logic [1:0] MODE_8RL = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    // Prescale field codes
    localparam logic [1:0] PS_DIV12 = 2'h0;
    localparam logic [1:0] PS_DIV4 = 2'h1;
    localparam logic [1:0] PS_DIV48 = 2'h2;
    localparam logic [1:0] PS_EXT8 = 2'h3;
    localparam int DIV12 = 12;
    localparam int DIV4 = 4;
    localparam int DIV48 = 48;
    localparam int EXT_DIV = 8;
    // CTRL field positions
    localparam int CTRL_RUN0 = 0;
    localparam int CTRL_TIMER_ZERO_GATE_BIT = 1;
    localparam int CTRL_CNT0 = 2;
    localparam int CTRL_MODE0 = 3;
    localparam int CTRL_RUN1 = 8;
    localparam int CTRL_GATE1 = 9;
    localparam int CTRL_CNT1 = 10;
    localparam int CTRL_MODE1 = 11;
    localparam int CTRL_RUN2 = 16;
    localparam int CTRL_SPLIT2 = 17;
    localparam int CTRL_RUN3 = 24;
    localparam int CTRL_SPLIT3 = 25;
    localparam int CTRL_SUSP = 31;
    // CLKCFG field positions
    localparam int CFG_PS = 0;
    localparam int CFG_CS0 = 2;
    localparam int CFG_CS1 = 3;
    localparam int CFG_T2CK = 4;
    localparam int CFG_T3CK = 6;
    // Timer 2/3 clock codes
    localparam logic [1:0] CK_SYS = 2'h0;
    localparam logic [1:0] CK_DIV12 = 2'h1;
    localparam logic [1:0] CK_EXT8 = 2'h2;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: testbench/test_quad_timer_counter_unit.sv */
// Self-checking bench for the quad timer unit
`default_nettype none
module test_quad_timer_counter_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, ext_osc_clk = 0, irq, wake;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_arready, s_axi_rvalid, s_axi_bvalid;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, ec = 0;
    logic timer_zero_event_pin = 1, timer_one_event_pin = 1;
    logic external_gate_input_zero = 0, external_gate_input_one = 0;
    typedef struct {logic [31:0] m; logic [31:0] v; logic [1:0] r;} note_t;
    note_t qr[$], nr;
    logic [1:0] qb[$];
    logic [31:0] rd_v, a0;
    logic [15:0] dv;
    int n_fail = 0, samples_checked = 0, cyc = 0, wake_cnt = 0, n, w;
    int td[8] = '{12, 4, 48, 64, 1, 1, 12, 64};
    logic [31:0] tg[8] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h8, 32'h0, 32'h10, 32'h20};

    quad_timer_counter_unit dut (.*);

    initial forever #2.5 aclk = ~aclk;

    // Slow external oscillator, period of eight system clocks
    always @(posedge aclk) begin
        ec <= ec + 2'h1;
        if (ec == 2'h3) ext_osc_clk <= ~ext_osc_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Monitor: oldest note is matched against each bus answer
    always @(posedge aclk) begin
        cyc++;
        if (wake === 1'b1) wake_cnt++;
        if (s_axi_rvalid === 1'b1 && s_axi_rready && qr.size() > 0) begin
            nr = qr.pop_front();
            check({30'h0, s_axi_rresp}, {30'h0, nr.r});
            if (nr.m != 0) check(s_axi_rdata & nr.m, nr.v);
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready && qb.size() > 0)
            check({30'h0, s_axi_bresp}, {30'h0, qb.pop_front()});
        if (cyc > 30000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        qb.push_back(2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid === 1'b1) done = 1;
        end while (!done);
        // Ready left high: no re-raise in the same step by the next call
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                      input logic [1:0] r);
        bit done;
        done = 0;
        qr.push_back('{m, v, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid === 1'b1) begin
                rd_v = s_axi_rdata;
                done = 1;
            end
        end while (!done);
    endtask

    // Each level held two cycles, twice the one cycle the counter input needs
    task automatic edges(input int k);
        repeat (k) begin
            timer_zero_event_pin <= 0;
            repeat (2) @(posedge aclk);
            timer_zero_event_pin <= 1;
            repeat (2) @(posedge aclk);
        end
        repeat (8) @(posedge aclk);
    endtask

    initial begin
        void'($urandom(32'hd66a9cba));
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 10; i++) rd(8'(4 * i), 32'hffffffff, timer_pkg::RESET_VAL, 2'h0);
        rd(8'h40, 32'h0, 32'h0, 2'h2);
        $display("test reset done");
        n = $urandom_range(3, 20);
        wr(timer_pkg::OFF_CTRL, 32'h0000_000e);
        edges(3);
        rd(timer_pkg::OFF_T0, 32'hffff, 32'h0, 2'h0);
        wr(timer_pkg::OFF_CTRL, 32'h0000_000f);
        edges(3);
        rd(timer_pkg::OFF_T0, 32'hffff, 32'h0, 2'h0);
        external_gate_input_zero <= 1;
        edges(n);
        rd(timer_pkg::OFF_T0, 32'hffff, 32'(n), 2'h0);
        wr(timer_pkg::OFF_CLKCFG, 32'h4);
        wr(timer_pkg::OFF_CTRL, 32'h0000_000d);
        edges(n);
        rd(timer_pkg::OFF_T0, 32'hffff, 32'(2 * n), 2'h0);
        $display("test event count done");
        wr(timer_pkg::OFF_CTRL, 32'h5);
        wr(timer_pkg::OFF_T0, 32'hff1f);
        edges(1);
        rd(timer_pkg::OFF_T0, 32'hffff, 32'h0, 2'h0);
        check({31'h0, irq}, 32'h0);
        wr(timer_pkg::OFF_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h1);
        rd(timer_pkg::OFF_STAT, 32'h1, 32'h1, 2'h0);
        rd(timer_pkg::OFF_STAT, 32'h3f, 32'h0, 2'h0);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        $display("test overflow done");
        wr(timer_pkg::OFF_T0, 32'h40fe);
        wr(timer_pkg::OFF_CTRL, 32'h15);
        edges(3);
        rd(timer_pkg::OFF_T0, 32'hffff, 32'h4041, 2'h0);
        // Split low byte counts events; high byte idle without run1
        wr(timer_pkg::OFF_T0, 32'h12fe);
        wr(timer_pkg::OFF_CTRL, 32'h1d);
        edges(3);
        rd(timer_pkg::OFF_T0, 32'hffff, 32'h1201, 2'h0);
        $display("test reload and split done");
        // Rate measured between two reads, which share the same latency
        for (int i = 0; i < 8; i++) begin
            wr(timer_pkg::OFF_CTRL, i < 5 ? 32'h0000_0900 : 32'h0001_0000);
            wr(timer_pkg::OFF_CLKCFG, tg[i]);
            w = $urandom_range(400, 800);
            rd(i < 5 ? timer_pkg::OFF_T1 : timer_pkg::OFF_T2, 32'h0, 32'h0, 2'h0);
            a0 = rd_v;
            repeat (w) @(posedge aclk);
            rd(i < 5 ? timer_pkg::OFF_T1 : timer_pkg::OFF_T2, 32'h0, 32'h0, 2'h0);
            dv = rd_v[15:0] - a0[15:0];
            check({31'h0, dv >= w / td[i] - 1 && dv <= (w + 6) / td[i] + 1}, 32'h1);
        end
        $display("test clock rates done");
        // Both halves wrap every sixteen cycles once on the system clock
        wr(timer_pkg::OFF_T2RL, 32'hf0f0);
        wr(timer_pkg::OFF_CTRL, 32'h0003_0000);
        wr(timer_pkg::OFF_T2, 32'hfefe);
        wr(timer_pkg::OFF_CLKCFG, 32'h0);
        repeat (40) @(posedge aclk);
        rd(timer_pkg::OFF_STAT, 32'h28, 32'h28, 2'h0);
        $display("test timer two split done");
        wr(timer_pkg::OFF_CTRL, 32'h0);
        wr(timer_pkg::OFF_T3, 32'hffff);
        wr(timer_pkg::OFF_CLKCFG, 32'h80);
        wr(timer_pkg::OFF_MASK, 32'h10);
        wr(timer_pkg::OFF_CTRL, 32'h8100_0000);
        repeat (200) @(posedge aclk);
        check(32'(wake_cnt), 32'h1);
        check({31'h0, irq}, 32'h1);
        rd(timer_pkg::OFF_STAT, 32'h10, 32'h10, 2'h0);
        $display("test suspend wake done");
        finish_test();
    end
endmodule
`default_nettype wire

/* File: testbench/timer_checker.sv */
// Port-level checks on the quad timer unit bus and wake-up output
`default_nettype none
module timer_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq,
    input wire logic wake
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read answer missing");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer open");
    chk_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_write_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write answer missing");
    chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write accepted while pending");
    chk_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    chk_wake_pulse: assert property (wake |=> !wake)
        else $error("wake longer than one cycle");
    chk_reset_quiet: assert property ($rose(aresetn) |-> !irq && !wake && !s_axi_bvalid)
        else $error("outputs active after reset");
endmodule
bind quad_timer_counter_unit timer_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .irq, .wake);
`default_nettype wire
